// ===== hdl/plc1_indicator_ctrl.sv
// Summary of operation
// - 16-bit control register, resets to 0x0001
// - bit 10 selects extended function set
// - five-bit function code picks one of 32
// - last pattern bit held one tick plus tick times multiplier
// - default blink half second on, half off
// - stretch select gives 32, 64, 102 ms
// - select 11 uses custom six-bit length
// - bit 1 high disables indicator outputs
// - bit 0 stretches tx, rx, collision pulses
`timescale 1ns/100ps
`default_nettype none

module plc1_indicator_ctrl
   import plc1_pkg::*;
#(
   parameter int MS_CYCLES = PLC1_MS_CYCLES,
   parameter int PAT_UNIT_MS = PLC1_PAT_UNIT_MS,
   parameter bit PIN_ACTIVE = 1'b1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Management register port
   input wire logic [4:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [15:0] reg_wdata_i,
   output logic [15:0] reg_rdata_o,
   // Fields held in neighbouring registers
   input wire logic [3:0] indicator_function_low_bits_i,
   input wire logic [5:0] stretch_length_custom_i,
   input wire logic [7:0] blink_pattern_bits_i,
   input wire logic [5:0] pattern_tick_length_i,
   // Link state and raw activity
   input wire plc1_link_t link_i,
   input wire plc1_act_t act_i,
   // Indicator pin
   output logic indicator_pin_zero_o,
   output logic indicator_pin_zero_oe_o
);

   logic [15:0] ctrl_q;
   logic ext_sel;
   logic [3:0] hold_mult;
   logic [1:0] str_sel;
   logic oe_n;
   logic str_en;
   logic [4:0] func_code;
   logic [6:0] str_len;
   logic [$clog2(MS_CYCLES)-1:0] ms_cnt_q;
   logic ms_tick;
   logic [$clog2(PAT_UNIT_MS+1)-1:0] unit_cnt_q;
   logic unit_tick;
   logic [5:0] tick_cnt_q;
   logic pat_tick;
   plc1_blink_t bl_state_q;
   logic [2:0] bit_idx_q;
   logic [3:0] hold_cnt_q;
   logic blink_q;
   logic [6:0] str_cnt_q [3];
   plc1_act_t act_q;
   plc1_act_t act_s;
   logic lit;
   logic sel_hit;

   assign sel_hit = (reg_addr_i == PLC1_CTRL_ONE_ADDR);
   assign ext_sel = ctrl_q[PLC1_EXT_BIT];
   assign hold_mult = ctrl_q[PLC1_HOLD_LSB +: PLC1_HOLD_W];
   assign str_sel = ctrl_q[PLC1_SEL_LSB +: 2];
   assign oe_n = ctrl_q[PLC1_OE_N_BIT];
   assign str_en = ctrl_q[PLC1_STR_EN_BIT];

   // Register write; read-only bits never store
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q <= PLC1_CTRL_ONE_RST;
      end else if (reg_wr_i && sel_hit) begin
         ctrl_q <= reg_wdata_i & PLC1_CTRL_ONE_WMASK;
      end
   end

   // Read data registered; other addresses answer zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= 16'h0000;
      end else if (reg_rd_i) begin
         reg_rdata_o <= sel_hit ? ctrl_q : 16'h0000;
      end
   end

   assign func_code = {ext_sel, indicator_function_low_bits_i};

   // Stretch length in ms
   always_comb begin
      unique case (str_sel)
         2'h0: str_len = PLC1_STR_MS_32;
         2'h1: str_len = PLC1_STR_MS_64;
         2'h2: str_len = PLC1_STR_MS_102;
         PLC1_SEL_CUSTOM: str_len = {1'b0, stretch_length_custom_i};
      endcase
   end

   // Millisecond enable shared by stretch and pattern timing
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ms_cnt_q <= '0;
      end else if (ms_tick) begin
         ms_cnt_q <= '0;
      end else begin
         ms_cnt_q <= ms_cnt_q + 1'b1;
      end
   end
   assign ms_tick = (ms_cnt_q == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         unit_cnt_q <= '0;
      end else if (unit_tick) begin
         unit_cnt_q <= '0;
      end else if (ms_tick) begin
         unit_cnt_q <= unit_cnt_q + 1'b1;
      end
   end
   assign unit_tick = ms_tick &&
      (unit_cnt_q == ($clog2(PAT_UNIT_MS+1))'(PAT_UNIT_MS - 1));

   // Tick length of zero is taken as one unit
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_cnt_q <= '0;
      end else if (pat_tick) begin
         tick_cnt_q <= '0;
      end else if (unit_tick) begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
      end
   end
   assign pat_tick = unit_tick && (tick_cnt_q + 6'h01 >= pattern_tick_length_i);

   // Pattern shifter with hold of the last bit
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         bl_state_q <= PLC1_BL_SHIFT;
         bit_idx_q <= '0;
         hold_cnt_q <= '0;
         blink_q <= 1'b0;
      end else if (pat_tick) begin
         unique case (bl_state_q)
            PLC1_BL_SHIFT: begin
               blink_q <= blink_pattern_bits_i[bit_idx_q];
               bit_idx_q <= bit_idx_q + 1'b1;
               if (bit_idx_q == PLC1_PAT_LAST && hold_mult != 4'h0) begin
                  bl_state_q <= PLC1_BL_HOLD;
                  hold_cnt_q <= hold_mult;
               end
            end
            PLC1_BL_HOLD: begin
               hold_cnt_q <= hold_cnt_q - 1'b1;
               if (hold_cnt_q == 4'h1) begin
                  bl_state_q <= PLC1_BL_SHIFT;
               end
            end
         endcase
      end
   end

   // Per-event stretch counters, reloaded on each raw pulse
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         act_q <= '0;
      end else begin
         act_q <= act_i;
      end
   end

   for (genvar g = 0; g < 3; g++) begin : g_str
      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            str_cnt_q[g] <= '0;
         end else if (!str_en) begin
            str_cnt_q[g] <= '0;
         end else if (act_q[g]) begin
            str_cnt_q[g] <= str_len;
         end else if (ms_tick && str_cnt_q[g] != 7'h00) begin
            str_cnt_q[g] <= str_cnt_q[g] - 1'b1;
         end
      end
      assign act_s[g] = act_q[g] || (str_cnt_q[g] != 7'h00);
   end

   // Function decode; reserved and unlisted codes stay dark
   always_comb begin
      logic act;
      logic l10;
      logic l100;
      act = act_s.tx || act_s.rx;
      l10 = link_i.link_up && !link_i.speed_100;
      l100 = link_i.link_up && link_i.speed_100;
      unique case (func_code)
         PLC1_F_ON10_BL100: lit = l10 || (l100 && blink_q);
         PLC1_F_ON10: lit = l10;
         PLC1_F_ON100_BL10: lit = l100 || (l10 && blink_q);
         PLC1_F_ON100: lit = l100;
         PLC1_F_BL10: lit = l10 && blink_q;
         PLC1_F_BLTX: lit = act_s.tx && blink_q;
         PLC1_F_BLACT: lit = act && blink_q;
         PLC1_F_100_ACT: lit = l100 && (!act || blink_q);
         PLC1_F_10_ACT: lit = l10 && (!act || blink_q);
         PLC1_F_LINK: lit = link_i.link_up;
         PLC1_F_OFF: lit = 1'b0;
         PLC1_F_ON: lit = 1'b1;
         PLC1_F_BLINK: lit = blink_q;
         PLC1_F_FD_COL: lit = link_i.link_up && link_i.full_duplex &&
            (!act_s.col || blink_q);
         PLC1_F_LINK_RX: lit = link_i.link_up && (!act_s.rx || blink_q);
         PLC1_F_LINK_ACT: lit = link_i.link_up && (!act || blink_q);
         PLC1_F_COL: lit = act_s.col;
         PLC1_F_FD: lit = link_i.link_up && link_i.full_duplex;
         PLC1_F_ACT: lit = act;
         PLC1_F_RX: lit = act_s.rx;
         default: lit = 1'b0;
      endcase
   end

   // Pin forced inactive while outputs are disabled
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         indicator_pin_zero_o <= ~PIN_ACTIVE;
         indicator_pin_zero_oe_o <= 1'b0;
      end else begin
         indicator_pin_zero_o <= (lit && !oe_n) ? PIN_ACTIVE : ~PIN_ACTIVE;
         indicator_pin_zero_oe_o <= !oe_n;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_write_ctrl;
      reg_wr_i && sel_hit;
   endsequence

   sequence s_read_ctrl;
      reg_rd_i && sel_hit && !reg_wr_i;
   endsequence

   read_back_a: assert property (
      s_write_ctrl ##1 s_read_ctrl |=>
         reg_rdata_o == ($past(reg_wdata_i, 2) & PLC1_CTRL_ONE_WMASK))
      else $error("control register read back mismatch");

   ro_bits_a: assert property (ctrl_q[9:8] == 2'h0)
      else $error("read-only bits stored a value");

   ext_set_a: assert property (
      s_write_ctrl |=> func_code[4] == $past(reg_wdata_i[PLC1_EXT_BIT]))
      else $error("extended set bit not applied");

   oe_off_a: assert property (
      oe_n |=> (indicator_pin_zero_o == ~PIN_ACTIVE) &&
         !indicator_pin_zero_oe_o)
      else $error("indicator driven while disabled");

   sel_len_a: assert property (
      str_sel == 2'h2 |-> str_len == PLC1_STR_MS_102)
      else $error("stretch length for select 10 wrong");

   custom_len_a: assert property (
      str_sel == PLC1_SEL_CUSTOM && str_en && act_q.rx |=>
         str_cnt_q[1] == {1'b0, $past(stretch_length_custom_i)})
      else $error("custom stretch length not loaded");

   stretch_hold_a: assert property (
      str_en && act_q.rx && str_len > 7'h01 ##1 !act_q.rx |->
         act_s.rx)
      else $error("receive pulse not stretched");

   no_stretch_a: assert property (
      !str_en |=> act_s == act_q)
      else $error("stretch applied while disabled");

   hold_bit_a: assert property (
      bl_state_q == PLC1_BL_HOLD |=> $stable(blink_q))
      else $error("pattern bit changed during hold");

   hold_enter_a: assert property (
      pat_tick && bl_state_q == PLC1_BL_SHIFT &&
         bit_idx_q == PLC1_PAT_LAST && hold_mult != 4'h0 |=>
         bl_state_q == PLC1_BL_HOLD && hold_cnt_q == $past(hold_mult))
      else $error("hold phase not entered after last bit");

endmodule : plc1_indicator_ctrl

`default_nettype wire

// ===== pkg/plc1_pkg.sv
package plc1_pkg;

   // Register location and layout
   localparam logic [4:0] PLC1_CTRL_ONE_ADDR = 5'h1B;
   localparam logic [15:0] PLC1_CTRL_ONE_RST = 16'h0001;
   // Bits 9:8 are read-only zero, everything else is stored
   localparam logic [15:0] PLC1_CTRL_ONE_WMASK = 16'hFCFF;
   localparam int PLC1_EXT_BIT = 10;
   localparam int PLC1_HOLD_LSB = 4;
   localparam int PLC1_HOLD_W = 4;
   localparam int PLC1_SEL_LSB = 2;
   localparam int PLC1_OE_N_BIT = 1;
   localparam int PLC1_STR_EN_BIT = 0;

   // Stretch lengths in milliseconds
   localparam logic [1:0] PLC1_SEL_CUSTOM = 2'h3;
   localparam logic [6:0] PLC1_STR_MS_32 = 7'h20;
   localparam logic [6:0] PLC1_STR_MS_64 = 7'h40;
   localparam logic [6:0] PLC1_STR_MS_102 = 7'h66;

   // Timing
   localparam int PLC1_CLK_HZ = 25000000;
   localparam int PLC1_MS_PER_S = 1000;
   localparam int PLC1_MS_CYCLES = PLC1_CLK_HZ / PLC1_MS_PER_S;
   localparam int PLC1_PAT_UNIT_MS = 8;
   localparam logic [2:0] PLC1_PAT_LAST = 3'h7;

   // Function codes (extended bit on top)
   localparam logic [4:0] PLC1_F_ON10_BL100 = 5'h1F;
   localparam logic [4:0] PLC1_F_ON10 = 5'h1E;
   localparam logic [4:0] PLC1_F_ON100_BL10 = 5'h1D;
   localparam logic [4:0] PLC1_F_ON100 = 5'h1C;
   localparam logic [4:0] PLC1_F_BL10 = 5'h1B;
   localparam logic [4:0] PLC1_F_BLTX = 5'h1A;
   localparam logic [4:0] PLC1_F_BLACT = 5'h19;
   localparam logic [4:0] PLC1_F_100_ACT = 5'h13;
   localparam logic [4:0] PLC1_F_10_ACT = 5'h12;
   localparam logic [4:0] PLC1_F_LINK = 5'h10;
   localparam logic [4:0] PLC1_F_OFF = 5'h0F;
   localparam logic [4:0] PLC1_F_ON = 5'h0E;
   localparam logic [4:0] PLC1_F_BLINK = 5'h0D;
   localparam logic [4:0] PLC1_F_FD_COL = 5'h0C;
   localparam logic [4:0] PLC1_F_LINK_RX = 5'h0B;
   localparam logic [4:0] PLC1_F_LINK_ACT = 5'h0A;
   localparam logic [4:0] PLC1_F_COL = 5'h09;
   localparam logic [4:0] PLC1_F_FD = 5'h08;
   localparam logic [4:0] PLC1_F_ACT = 5'h07;
   localparam logic [4:0] PLC1_F_RX = 5'h06;

   typedef struct packed {
      logic col;
      logic rx;
      logic tx;
   } plc1_act_t;

   typedef struct packed {
      logic link_up;
      logic speed_100;
      logic full_duplex;
   } plc1_link_t;

   typedef enum logic {
      PLC1_BL_SHIFT = 1'b0,
      PLC1_BL_HOLD = 1'b1
   } plc1_blink_t;

endpackage : plc1_pkg

// ===== dv/plc1_lamp.sv
`timescale 1ns/100ps
`default_nettype none

module plc1_lamp #(
   parameter bit PIN_ACTIVE = 1'b1
) (
   // Pin from the board side
   input wire logic pin_i,
   input wire logic oe_i,
   // Observed light
   output logic lit_o
);
   // An undriven pin never lights the lamp
   assign lit_o = oe_i && (pin_i === PIN_ACTIVE);
endmodule : plc1_lamp

`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import plc1_pkg::*;
   // Short millisecond keeps stretch tests brief
   localparam int MS = 4;
   logic clk, rst, wr, rd, lit, pin, oe;
   logic [4:0] addr;
   logic [15:0] wd, rdata, cnt;
   logic [3:0] fl;
   logic [5:0] cust, tick;
   logic [7:0] pat;
   plc1_link_t link;
   plc1_act_t act;
   logic [6:0] lens [4];
   logic [31:0] masks [3];
   logic [2:0] links [3];
   int n_errors, num_checks, len;

   plc1_indicator_ctrl #(.MS_CYCLES(MS), .PAT_UNIT_MS(1)) dut (
      .clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata),
      .indicator_function_low_bits_i(fl), .stretch_length_custom_i(cust),
      .blink_pattern_bits_i(pat), .pattern_tick_length_i(tick),
      .link_i(link), .act_i(act), .indicator_pin_zero_o(pin),
      .indicator_pin_zero_oe_o(oe));
   plc1_lamp lamp (.pin_i(pin), .oe_i(oe), .lit_o(lit));

   always #20 clk = ~clk;

   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_val

   task automatic chk_lit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_lit

   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      @(negedge clk);
      addr = a;
      wd = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      chk_val(rdata, e);
   endtask : rd_chk

   // Write and read on consecutive edges
   task automatic wr_rd_chk(input logic [15:0] d, input logic [15:0] e);
      @(negedge clk);
      addr = 5'h1B;
      wd = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      chk_val(rdata, e);
   endtask : wr_rd_chk

   // Bounded count of negedges at which the lamp holds one level
   task automatic width_chk(input logic v, input logic [15:0] e);
      logic [15:0] n;
      n = 16'h0000;
      while (lit === v && n < 16'h00C8) begin
         @(negedge clk);
         n++;
      end
      chk_val(n, e);
   endtask : width_chk

   // Bounded wait for the lamp to reach a level
   task automatic wait_lit(input logic v);
      int i;
      i = 0;
      while (lit !== v && i < 400) begin
         @(negedge clk);
         i++;
      end
      chk_lit(lit, v);
   endtask : wait_lit

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_sim();
   end

   initial begin
      clk = 1'b0; rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 5'h00;
      wd = 16'h0000; fl = 4'hA; cust = 6'h05; pat = 8'h80; tick = 6'h01;
      link = plc1_link_t'(3'h7); act = plc1_act_t'(3'h0);
      lens = '{PLC1_STR_MS_32, PLC1_STR_MS_64, PLC1_STR_MS_102, 7'h05};
      repeat (6) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      rd_chk(5'h1B, 16'h0001);
      wr_reg(5'h1B, 16'hFFFF);
      rd_chk(5'h1B, 16'hFCFF);
      wr_reg(5'h1A, 16'h1234);
      rd_chk(5'h1A, 16'h0000);
      rd_chk(5'h1B, 16'hFCFF);
      wr_rd_chk(16'hA5F3, 16'hA4F3);
      wr_reg(5'h1B, 16'h0000);
      fl = 4'hE;
      repeat (4) @(negedge clk);
      chk_lit(lit, 1'b1);
      fl = 4'hF;
      repeat (4) @(negedge clk);
      chk_lit(lit, 1'b0);
      fl = 4'h0;
      wr_reg(5'h1B, 16'h0400);
      repeat (4) @(negedge clk);
      chk_lit(lit, 1'b1);
      wr_reg(5'h1B, 16'h0000);
      repeat (4) @(negedge clk);
      chk_lit(lit, 1'b0);
      fl = 4'hE;
      wr_reg(5'h1B, 16'h0002);
      repeat (2) @(negedge clk);
      chk_lit(oe, 1'b0);
      chk_lit(lit, 1'b0);
      // Receive-only code so a single rx pulse is the only cause
      fl = 4'h6;
      for (int s = 0; s < 4; s++) begin
         wr_reg(5'h1B, 16'h0001 | (16'(s) << 2));
         len = int'(lens[s]) * MS;
         @(negedge clk) act.rx = 1'b1;
         @(negedge clk) act.rx = 1'b0;
         repeat (len - 3) @(negedge clk);
         chk_lit(lit, 1'b1);
         repeat (13) @(negedge clk);
         chk_lit(lit, 1'b0);
      end
      wr_reg(5'h1B, 16'h0000);
      @(negedge clk) act.rx = 1'b1;
      @(negedge clk) act.rx = 1'b0;
      repeat (5) @(negedge clk);
      chk_lit(lit, 1'b0);
      // Whole function table with the pattern dark, so blinking reads off
      pat = 8'h00;
      repeat (8) @(negedge clk);
      masks = '{32'h30095D00, 32'hC0055D00, 32'h30015980};
      links = '{3'h7, 3'h5, 3'h7};
      for (int m = 0; m < 3; m++) begin
         link = plc1_link_t'(links[m]);
         act.tx = (m == 2);
         for (int c = 0; c < 32; c++) begin
            wr_reg(5'h1B, c[4] ? 16'h0400 : 16'h0000);
            fl = c[3:0];
            repeat (3) @(negedge clk);
            chk_lit(lit, masks[m][c]);
         end
      end
      act.tx = 1'b0;
      link = plc1_link_t'(3'h7);
      pat = 8'h80;
      // Only the last pattern bit lights, so its width shows the hold
      fl = 4'hD;
      for (int h = 0; h < 6; h += 5) begin
         wr_reg(5'h1B, 16'(h) << 4);
         wait_lit(1'b0);
         wait_lit(1'b1);
         wait_lit(1'b0);
         wait_lit(1'b1);
         cnt = 16'h0000;
         while (lit === 1'b1 && cnt < 16'h00C8) begin
            @(negedge clk);
            cnt++;
         end
         chk_val(cnt, 16'((1 + h) * MS));
      end
      // Equal lit and dark halves, as in the default blink
      pat = 8'h0F;
      wr_reg(5'h1B, 16'h0000);
      wait_lit(1'b1);
      wait_lit(1'b0);
      wait_lit(1'b1);
      width_chk(1'b1, 16'(4 * MS));
      width_chk(1'b0, 16'(4 * MS));
      end_sim();
   end
endmodule : testbench

`default_nettype wire
